// [rtl/isb_pkg.sv]
// Purpose: Shared constants for the inertial serial register and burst port
// Assumes: 16-bit words, 7-bit byte addresses, 100 MHz system clock
// Notes: Page 3 offsets and the marker-choice thresholds are named here once
package isb_pkg;

  // Word and command layout
  localparam int WORD_W = 16;
  localparam int DIR_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [15:0] BURST_CMD = 16'h7c00;
  localparam logic [15:0] FRAME_MARKER_WORD = 16'ha5a5;
  localparam logic [15:0] NULL_WORD = 16'h0000;

  // Burst frame layout after the markers
  localparam int FRAME_WORDS = 17;
  localparam int AXIS_WORDS = 6;
  localparam int FR_SYS = 0;
  localparam int FR_TEMP = 1;
  localparam int FR_RATE = 2;
  localparam int FR_ACCEL = 8;
  localparam int FR_CNT = 14;
  localparam int FR_CHK_LO = 15;
  localparam int FR_CHK_HI = 16;
  localparam logic [4:0] SEG_NULL = 5'h01;
  localparam logic [4:0] SEG_MARK1 = 5'h02;
  localparam logic [4:0] SEG_MARK2 = 5'h03;
  localparam logic [4:0] DATA_OFS_ONE = 5'h03;
  localparam logic [4:0] DATA_OFS_TWO = 5'h04;
  localparam logic [4:0] SEG_LAST_ONE = 5'h13;
  localparam logic [4:0] SEG_LAST_TWO = 5'h14;

  // Pages and byte addresses (word aligned, low byte)
  localparam logic [15:0] PAGE_DATA = 16'h0000;
  localparam logic [15:0] PAGE_CTRL = 16'h0003;
  localparam logic [6:0] ADDR_PAGE = 7'h00;
  localparam logic [6:0] ADDR_CNT = 7'h04;
  localparam logic [6:0] ADDR_SYS = 7'h08;
  localparam logic [6:0] ADDR_TEMP = 7'h0e;
  localparam logic [6:0] ADDR_RATE = 7'h10;
  localparam logic [6:0] ADDR_AXIS_LAST = 7'h26;
  localparam logic [6:0] ADDR_TSTAMP = 7'h28;
  localparam logic [6:0] ADDR_CHK_LO = 7'h2a;
  localparam logic [6:0] ADDR_CHK_HI = 7'h2c;
  localparam logic [6:0] ADDR_GCMD = 7'h02;
  localparam logic [6:0] ADDR_FUNC = 7'h06;

  // Field positions and reset values
  localparam logic [15:0] PAGE_RESET = 16'h0000;
  localparam logic [15:0] FUNC_RESET = 16'h000d;
  localparam int FUNC_SEL_MSB = 8;
  localparam int FUNC_SEL_LSB = 7;
  localparam logic [1:0] FUNC_SEL_TSTAMP = 2'h3;
  localparam int GCMD_SAVE_BIT = 3;
  localparam int SYS_BACKUP_BIT = 2;

  // Serial clock rate limits that pick one or two markers
  localparam int CLK_KHZ = 100000;
  localparam int SLOW_LIMIT_KHZ = 3000;
  localparam int FAST_LIMIT_KHZ = 3600;
  localparam logic [7:0] SLOW_MIN_CYC = 8'((CLK_KHZ + SLOW_LIMIT_KHZ - 1) / SLOW_LIMIT_KHZ);
  localparam logic [7:0] FAST_MAX_CYC = 8'(CLK_KHZ / FAST_LIMIT_KHZ);
  localparam logic [7:0] PERIOD_SAT = 8'hff;
  localparam logic [7:0] PERIOD_ONE = 8'h01;

  typedef enum logic [1:0] {BOOT_START, BOOT_WAIT, BOOT_DONE} isb_boot_t;

endpackage

// [rtl/isb_link.sv]
// Purpose: Serial-clock side of the port: shifting, burst sequencing, output
// Assumes: Mode 3, MSB first, cs_b resets the word state asynchronously
// Notes: rd_word, frame_words and two_markers are held still by the system side
module isb_link (
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic link_rst_b,
  input wire logic mosi,
  input wire logic two_markers,
  input wire logic [15:0] rd_word,
  input wire logic [15:0] frame_words [isb_pkg::FRAME_WORDS],
  output logic miso,
  output logic miso_oe,
  output logic [15:0] rx_word,
  output logic rx_toggle
);
  import isb_pkg::*;

  logic [3:0] bit_cnt_reg;
  logic [14:0] rx_sh_reg;
  logic burst_reg;
  logic [4:0] seg_reg;
  logic rd_pending_reg;
  logic [15:0] tx_sh_reg;
  logic [15:0] word_in;
  logic [15:0] tx_next;
  logic [4:0] seg_last;
  logic [4:0] data_idx;

  assign word_in = {rx_sh_reg, mosi};
  assign seg_last = two_markers ? SEG_LAST_TWO : SEG_LAST_ONE;
  assign data_idx = seg_reg - (two_markers ? DATA_OFS_TWO : DATA_OFS_ONE);

  // Input shifting on rising edges; chip select high drops any partial word
  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      bit_cnt_reg <= BIT_FIRST;
      rx_sh_reg <= 15'h0000;
      burst_reg <= 1'b0;
      seg_reg <= 5'h00;
      rd_pending_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      rx_sh_reg <= word_in[14:0];
      if (bit_cnt_reg == BIT_LAST) begin
        if (burst_reg) begin
          // No commands are decoded while the frame streams out
          seg_reg <= seg_reg + 5'h01;
          if (seg_reg == seg_last) begin
            burst_reg <= 1'b0;
          end
        end else begin
          rd_pending_reg <= !word_in[DIR_BIT] && (word_in != BURST_CMD);
          if (word_in == BURST_CMD) begin
            burst_reg <= 1'b1;
            seg_reg <= SEG_NULL;
          end
        end
      end
    end
  end

  // Completed words outside a burst go to the system side; the toggle survives chip select
  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rx_word <= NULL_WORD;
      rx_toggle <= 1'b0;
    end else if (!cs_b && bit_cnt_reg == BIT_LAST && !burst_reg) begin
      rx_word <= word_in;
      rx_toggle <= !rx_toggle;
    end
  end

  // Word chosen for the next transfer
  always_comb begin
    tx_next = NULL_WORD;
    if (burst_reg) begin
      if (seg_reg == SEG_NULL) begin
        tx_next = NULL_WORD;
      end else if (seg_reg == SEG_MARK1) begin
        tx_next = FRAME_MARKER_WORD;
      end else if (seg_reg == SEG_MARK2 && two_markers) begin
        tx_next = FRAME_MARKER_WORD;
      end else if (data_idx < 5'(FRAME_WORDS)) begin
        tx_next = frame_words[data_idx];
      end
    end else if (rd_pending_reg) begin
      tx_next = rd_word;
    end
  end

  // Output shifting on falling edges; released while chip select is high
  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b) begin
      tx_sh_reg <= NULL_WORD;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= 1'b1;
      if (bit_cnt_reg == BIT_FIRST) begin
        tx_sh_reg <= tx_next;
      end else begin
        tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
      end
    end
  end

  assign miso = tx_sh_reg[WORD_W - 1];

endmodule // isb_link

// [rtl/isb_port.sv]
// Purpose: Serial register and burst port of an inertial sensor module
// Assumes: clk at 100 MHz; sclk, cs_b, mosi come from the serial master
// Notes: Single reads need the master to idle between words; bursts do not
module isb_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic mid_rate_two_markers,
  input wire logic [15:0] system_error_flags,
  input wire logic [15:0] temperature_word,
  input wire logic [15:0] rate_words [isb_pkg::AXIS_WORDS],
  input wire logic [15:0] accel_words [isb_pkg::AXIS_WORDS],
  input wire logic [15:0] sample_counter,
  input wire logic [15:0] time_stamp,
  input wire logic [15:0] frame_check_low,
  input wire logic [15:0] frame_check_high,
  input wire logic flash_bank_latest,
  input wire logic image_crc_ready,
  input wire logic [31:0] image_crc_sram,
  input wire logic [31:0] image_crc_flash,
  output logic [15:0] page_select_reg,
  output logic [15:0] pin_function_control,
  output logic flash_save_pulse,
  output logic flash_save_bank,
  output logic image_load_req,
  output logic image_load_bank,
  output logic boot_done,
  output logic backup_boot
);
  import isb_pkg::*;

  logic rst_s1_reg;
  logic rst_n;
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic sck_s1_reg;
  logic sck_s2_reg;
  logic sck_s3_reg;
  logic [7:0] period_cnt_reg;
  logic [7:0] period_reg;
  logic two_markers_reg;
  logic [15:0] frame_reg [FRAME_WORDS];
  logic [15:0] frame_live [FRAME_WORDS];
  logic [15:0] rd_word_reg;
  logic [15:0] rx_word;
  logic rx_toggle;
  logic rx_event;
  logic is_write;
  logic is_burst;
  logic [6:0] rx_addr;
  logic [6:0] word_addr;
  logic [7:0] rx_data;
  logic [15:0] rd_mux;
  logic [6:0] axis_ofs;
  logic latest_bank_reg;
  isb_boot_t boot_state_reg;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Serial-clock side; words come back as a toggle and a held word
  isb_link u_link (
    .sclk(sclk),
    .cs_b(cs_b),
    .link_rst_b(rst_n),
    .mosi(mosi),
    .two_markers(two_markers_reg),
    .rd_word(rd_word_reg),
    .frame_words(frame_reg),
    .miso(miso),
    .miso_oe(miso_oe),
    .rx_word(rx_word),
    .rx_toggle(rx_toggle)
  );

  // Word-done toggle and serial clock brought into the system clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
      sck_s3_reg <= 1'b1;
    end else begin
      tgl_s1_reg <= rx_toggle;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      sck_s1_reg <= sclk;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
    end
  end

  // rx_word is stable for a whole word after the toggle, so it is read directly
  assign rx_event = tgl_s2_reg ^ tgl_s3_reg;
  assign is_write = rx_word[DIR_BIT];
  assign is_burst = (rx_word == BURST_CMD);
  assign rx_addr = rx_word[ADDR_MSB:ADDR_LSB];
  assign word_addr = {rx_addr[6:1], 1'b0};
  assign rx_data = rx_word[DATA_MSB:0];
  assign axis_ofs = 7'((word_addr - ADDR_RATE) >> 1);

  // Serial clock period in system cycles, measured rising edge to rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_reg <= PERIOD_ONE;
      period_reg <= PERIOD_SAT;
    end else if (sck_s2_reg && !sck_s3_reg) begin
      period_reg <= period_cnt_reg;
      period_cnt_reg <= PERIOD_ONE;
    end else if (period_cnt_reg != PERIOD_SAT) begin
      period_cnt_reg <= period_cnt_reg + PERIOD_ONE;
    end
  end

  // Live frame in burst order; counter slot follows the select field
  always_comb begin
    frame_live[FR_SYS] = system_error_flags;
    frame_live[FR_SYS][SYS_BACKUP_BIT] = backup_boot;
    frame_live[FR_TEMP] = temperature_word;
    for (int i = 0; i < AXIS_WORDS; i++) begin
      frame_live[FR_RATE + i] = rate_words[i];
      frame_live[FR_ACCEL + i] = accel_words[i];
    end
    if (pin_function_control[FUNC_SEL_MSB:FUNC_SEL_LSB] == FUNC_SEL_TSTAMP) begin
      frame_live[FR_CNT] = time_stamp;
    end else begin
      frame_live[FR_CNT] = sample_counter;
    end
    frame_live[FR_CHK_LO] = frame_check_low;
    frame_live[FR_CHK_HI] = frame_check_high;
  end

  // Burst request freezes the frame and the marker count for the whole burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      two_markers_reg <= 1'b0;
      for (int i = 0; i < FRAME_WORDS; i++) begin
        frame_reg[i] <= NULL_WORD;
      end
    end else if (rx_event && is_burst) begin
      if (period_reg <= FAST_MAX_CYC) begin
        two_markers_reg <= 1'b1;
      end else if (period_reg >= SLOW_MIN_CYC) begin
        two_markers_reg <= 1'b0;
      end else begin
        two_markers_reg <= mid_rate_two_markers;
      end
      frame_reg <= frame_live;
    end
  end

  // Read decode on the active page; either byte address gives the register
  always_comb begin
    rd_mux = NULL_WORD;
    if (word_addr == ADDR_PAGE) begin
      rd_mux = page_select_reg;
    end else if (page_select_reg == PAGE_DATA) begin
      if (word_addr == ADDR_CNT) begin
        rd_mux = sample_counter;
      end else if (word_addr == ADDR_SYS) begin
        rd_mux = frame_live[FR_SYS];
      end else if (word_addr == ADDR_TEMP) begin
        rd_mux = temperature_word;
      end else if (word_addr >= ADDR_RATE && word_addr <= ADDR_AXIS_LAST) begin
        rd_mux = frame_live[FR_RATE + int'(axis_ofs)];
      end else if (word_addr == ADDR_TSTAMP) begin
        rd_mux = time_stamp;
      end else if (word_addr == ADDR_CHK_LO) begin
        rd_mux = frame_check_low;
      end else if (word_addr == ADDR_CHK_HI) begin
        rd_mux = frame_check_high;
      end
    end else if (page_select_reg == PAGE_CTRL && word_addr == ADDR_FUNC) begin
      rd_mux = pin_function_control;
    end
  end

  // Read answer held for the next word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_reg <= NULL_WORD;
    end else if (rx_event && !is_write && !is_burst) begin
      rd_word_reg <= rd_mux;
    end
  end

  // Byte writes; the page register answers on every page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_select_reg <= PAGE_RESET;
      pin_function_control <= FUNC_RESET;
    end else if (rx_event && is_write) begin
      if (rx_addr == ADDR_PAGE) begin
        page_select_reg[7:0] <= rx_data;
      end else if (rx_addr == ADDR_PAGE + 7'h01) begin
        page_select_reg[15:8] <= rx_data;
      end else if (page_select_reg == PAGE_CTRL && rx_addr == ADDR_FUNC) begin
        pin_function_control[7:0] <= rx_data;
      end else if (page_select_reg == PAGE_CTRL && rx_addr == ADDR_FUNC + 7'h01) begin
        pin_function_control[15:8] <= rx_data;
      end
    end
  end

  // Flash save: always targets the bank not holding the newest image
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_save_pulse <= 1'b0;
      flash_save_bank <= 1'b0;
      latest_bank_reg <= 1'b0;
    end else begin
      flash_save_pulse <= 1'b0;
      if (boot_state_reg == BOOT_START) begin
        latest_bank_reg <= flash_bank_latest;
      end else if (rx_event && is_write && page_select_reg == PAGE_CTRL
                   && rx_addr == ADDR_GCMD && rx_data[GCMD_SAVE_BIT]) begin
        flash_save_pulse <= 1'b1;
        flash_save_bank <= !latest_bank_reg;
        latest_bank_reg <= !latest_bank_reg;
      end
    end
  end

  // Boot: load newest bank, check it, fall back once to the other bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_state_reg <= BOOT_START;
      image_load_req <= 1'b0;
      image_load_bank <= 1'b0;
      boot_done <= 1'b0;
      backup_boot <= 1'b0;
    end else begin
      image_load_req <= 1'b0;
      unique case (boot_state_reg)
        BOOT_START: begin
          image_load_bank <= flash_bank_latest;
          image_load_req <= 1'b1;
          boot_state_reg <= BOOT_WAIT;
        end
        BOOT_WAIT: begin
          if (image_crc_ready) begin
            if (image_crc_sram == image_crc_flash || backup_boot) begin
              boot_state_reg <= BOOT_DONE; // Second failure is not retried again
              boot_done <= 1'b1;
            end else begin
              image_load_bank <= !image_load_bank;
              image_load_req <= 1'b1;
              backup_boot <= 1'b1;
            end
          end
        end
        BOOT_DONE: begin
          boot_done <= 1'b1;
        end
      endcase
    end
  end

endmodule // isb_port

// [bench/isb_port_properties.sv]
// Purpose: Port checks for the serial register and burst port
// Assumes: One clk domain; cs_b is seen through clk sampling
// Notes: Bound into every isb_port instance
module isb_port_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic miso_oe,
  input wire logic image_crc_ready,
  input wire logic [31:0] image_crc_sram,
  input wire logic [31:0] image_crc_flash,
  input wire logic image_load_req,
  input wire logic boot_done,
  input wire logic backup_boot,
  input wire logic flash_save_pulse,
  input wire logic flash_save_bank,
  input wire logic [15:0] page_select_reg
);
  import isb_pkg::*;
  logic saved_reg;
  logic bank_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Remember the bank of the last save, so alternation can be judged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      saved_reg <= 1'b0;
      bank_reg <= 1'b0;
    end else if (flash_save_pulse) begin
      saved_reg <= 1'b1;
      bank_reg <= flash_save_bank;
    end
  end
  a_oe_released: assert property (cs_b |-> !miso_oe)
    else $error("miso enabled while deselected");
  a_oe_waits_clock: assert property ($fell(cs_b) |-> !miso_oe [*2])
    else $error("miso enabled before any serial clock");
  a_save_single: assert property (flash_save_pulse |=> !flash_save_pulse)
    else $error("save pulse longer than one clock");
  a_save_on_page: assert property (flash_save_pulse |-> page_select_reg == PAGE_CTRL)
    else $error("save outside the control page");
  a_bank_alternates: assert property (flash_save_pulse && saved_reg |->
    flash_save_bank != bank_reg)
    else $error("save bank did not alternate");
  a_boot_loads: assert property ($rose(rst_b) |-> ##[1:4] image_load_req)
    else $error("no image load after reset");
  a_retry_load: assert property (image_crc_ready && image_crc_sram != image_crc_flash &&
    !backup_boot |-> ##[1:4] image_load_req)
    else $error("no reload after check mismatch");
  a_match_done: assert property (image_crc_ready && image_crc_sram == image_crc_flash |->
    ##[1:4] boot_done)
    else $error("boot not done after check match");
  a_backup_holds: assert property (backup_boot |=> backup_boot)
    else $error("backup flag dropped");
  c_mismatch: cover property (image_crc_ready && image_crc_sram != image_crc_flash);
  c_second_save: cover property (flash_save_pulse && saved_reg);
  c_select: cover property ($fell(cs_b));
endmodule // isb_port_properties

bind isb_port isb_port_properties u_props (.clk, .rst_b, .cs_b, .miso_oe,
  .image_crc_ready, .image_crc_sram, .image_crc_flash, .image_load_req, .boot_done,
  .backup_boot, .flash_save_pulse, .flash_save_bank, .page_select_reg);

// [bench/isb_host_model.sv]
// Purpose: Serial master model in mode 3, 16-bit words
// Assumes: Caller picks the half period of every word
// Notes: A released miso reads as the inverse of the last bit seen
module isb_host_model (
  output logic sclk,
  output logic cs_b,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_bit = 1'b0;
  // Idle: deselected, clock parked high
  initial begin
    sclk = 1'b1;
    cs_b = 1'b1;
    mosi = 1'b0;
  end
  // Select or release with margin; mosi changes so a stale level is never reused
  task automatic select(input logic v);
    #100;
    cs_b = v;
    #100;
    mosi = ~mosi;
  endtask
  // One word, MSB first, out on fall and in on rise
  task automatic word(input logic [15:0] tx, output logic [15:0] rx, input realtime hp);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #hp;
      sclk = 1'b1;
      rx[i] = miso_oe ? miso : ~last_bit;
      last_bit = rx[i];
      #hp;
    end
  endtask
endmodule // isb_host_model

// [bench/tb_inertial_spi_register_burst_port.sv]
// Purpose: Self-checking bench for the serial register and burst port
// Assumes: Host model drives the link; sensor words are levels, changed only between transfers
// Notes: Fast words use a 125 ns serial period; bursts run slow, mid and fast
module tb_inertial_spi_register_burst_port;
  timeunit 1ns;
  timeprecision 100ps;
  import isb_pkg::*;
  localparam realtime FAST = 62.5;
  localparam int LIMIT = 60000;
  logic clk = 0;
  logic rst_b = 0;
  logic sclk, cs_b, mosi, miso, miso_oe, mid = 0, latest = 1, crc_rdy = 0, b0;
  logic [15:0] sys = 16'h1230, temp = 16'h2b11, cnt = 16'h5a01, tstamp = 16'h6b02;
  logic [15:0] chk_lo = 16'h7c03, chk_hi = 16'h8d04, page, func, rx;
  logic [15:0] rate [AXIS_WORDS];
  logic [15:0] accel [AXIS_WORDS];
  logic [15:0] frame [FRAME_WORDS];
  logic [15:0] req [7];
  logic [15:0] ans [7];
  logic [31:0] crc_s = 32'h1234abcd, crc_f = 32'h0;
  logic save_p, save_bank, load_req, load_bank, done, backup;
  logic banks [2];
  int nsave = 0, errors = 0, check_count = 0, cyc = 0;

  always #5 clk = ~clk;

  isb_port DUT (.clk, .rst_b, .sclk, .cs_b, .mosi, .miso, .miso_oe,
    .mid_rate_two_markers(mid), .system_error_flags(sys), .temperature_word(temp),
    .rate_words(rate), .accel_words(accel), .sample_counter(cnt), .time_stamp(tstamp),
    .frame_check_low(chk_lo), .frame_check_high(chk_hi), .flash_bank_latest(latest),
    .image_crc_ready(crc_rdy), .image_crc_sram(crc_s), .image_crc_flash(crc_f),
    .page_select_reg(page), .pin_function_control(func), .flash_save_pulse(save_p),
    .flash_save_bank(save_bank), .image_load_req(load_req), .image_load_bank(load_bank),
    .boot_done(done), .backup_boot(backup));

  isb_host_model u_host (.sclk, .cs_b, .mosi, .miso, .miso_oe);

  // Record the target bank of the first two saves, away from the launching edge
  always @(negedge clk) begin
    if (save_p === 1'b1 && nsave < 2) begin
      banks[nsave] = save_bank;
      nsave++;
    end
  end

  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Write word, then let the system side settle
  task automatic wr(input logic [15:0] w);
    u_host.word(w, rx, FAST);
    #200;
    @(negedge clk);
  endtask

  // Bounded wait for a load request
  task automatic wait_load();
    for (int i = 0; i < 20 && load_req !== 1'b1; i++) @(negedge clk);
    chk("load_req", 16'h0001, {15'h0, load_req});
    @(negedge clk);
  endtask

  // One-clock result from the loader
  task automatic crc_pulse(input logic [31:0] f);
    crc_f = f;
    crc_rdy = 1'b1;
    @(negedge clk);
    crc_rdy = 1'b0;
  endtask

  // Command, zero word, markers, frame; stop cuts the burst short
  task automatic burst(input realtime hp, input int nmark, input int stop);
    logic [15:0] e;
    u_host.select(1'b0);
    u_host.word(16'h7c00, rx, hp);
    for (int i = 0; i < 18 + nmark && i < stop; i++) begin
      u_host.word(16'h0000, rx, hp);
      e = i == 0 ? 16'h0000 : i <= nmark ? 16'ha5a5 : frame[i - 1 - nmark];
      chk("burst word", e, rx);
    end
    u_host.select(1'b1);
  endtask

  // Main sequence
  initial begin
    for (int k = 0; k < AXIS_WORDS; k++) begin
      rate[k] = 16'h3100 + 16'(k);
      accel[k] = 16'h4100 + 16'(k);
    end
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    wait_load();
    b0 = load_bank;
    crc_pulse(32'h0);
    wait_load();
    chk("load bank", {15'h0, ~b0}, {15'h0, load_bank});
    crc_pulse(crc_s);
    repeat (4) @(negedge clk);
    chk("boot_done", 16'h0001, {15'h0, done});
    chk("backup", 16'h0001, {15'h0, backup});
    frame[0] = sys | 16'h0004;
    frame[1] = temp;
    for (int k = 0; k < AXIS_WORDS; k++) begin
      frame[2 + k] = rate[k];
      frame[8 + k] = accel[k];
    end
    frame[14] = cnt;
    frame[15] = chk_lo;
    frame[16] = chk_hi;
    // Reads in one selection, each answer in the following word
    req = '{16'h1a00, 16'h1800, 16'h1b00, 16'h0800, 16'h3000, 16'h0000, 16'h0000};
    ans = '{rate[5], rate[4], rate[5], sys | 16'h0004, 16'h0, 16'h0, 16'h0};
    u_host.select(1'b0);
    for (int j = 0; j < 7; j++) begin
      u_host.word(req[j], rx, FAST);
      chk("read", j == 0 ? 16'h0 : ans[j - 1], rx);
      #200;
    end
    u_host.select(1'b1);
    burst(200, 1, 99);
    @(negedge clk);
    mid = 1'b1;
    burst(150, 2, 99);
    // Page change, byte-wise update, two saves
    u_host.select(1'b0);
    wr(16'h8003);
    wr(16'h8100);
    chk("page", 16'h0003, page);
    wr(16'h8680);
    chk("func low", 16'h0080, func);
    wr(16'h8701);
    chk("func high", 16'h0180, func);
    wr(16'h8208);
    wr(16'h8208);
    wr(16'h8000);
    wr(16'h8100);
    u_host.select(1'b1);
    chk("saves", 16'h0002, 16'(nsave));
    chk("bank 1", {15'h0, ~latest}, {15'h0, banks[0]});
    chk("bank 2", {15'h0, latest}, {15'h0, banks[1]});
    frame[14] = tstamp;
    burst(FAST, 2, 99);
    burst(FAST, 2, 5);
    @(negedge clk);
    temp = 16'h2c22; // A new level must show up in the next read
    u_host.select(1'b0);
    u_host.word(16'h0e00, rx, FAST);
    #200;
    u_host.word(16'h0000, rx, FAST);
    chk("read after abort", temp, rx);
    u_host.select(1'b1);
    // Mid-run reset: boot from the other bank, clean check, backup flag clear
    @(negedge clk);
    rst_b = 1'b0;
    latest = 1'b0;
    sys = 16'h0ff4;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    wait_load();
    chk("load bank 2", 16'h0000, {15'h0, load_bank});
    crc_pulse(crc_s);
    repeat (4) @(negedge clk);
    chk("boot_done 2", 16'h0001, {15'h0, done});
    chk("backup 2", 16'h0000, {15'h0, backup});
    // Flags read through the high byte address; bit 2 follows the boot, not the pin
    u_host.select(1'b0);
    u_host.word(16'h0900, rx, FAST);
    #200;
    u_host.word(16'h0000, rx, FAST);
    chk("flags no backup", 16'h0ff0, rx);
    u_host.select(1'b1);
    end_sim();
  end
endmodule // tb_inertial_spi_register_burst_port
